/* common/rf_tx_pkg.sv */
package rf_tx_pkg;

  // Sector select and register offsets
  localparam logic       SECTOR_ZERO             = 1'h0;
  localparam logic       SECTOR_ONE              = 1'h1;
  localparam logic [5:0] TRANSMITTER_CONTROL_OFS = 6'h11;
  localparam logic [5:0] CARRIER_LEVEL_OFS       = 6'h12;
  localparam logic [5:0] KEYED_LEVEL_OFS         = 6'h13;
  localparam logic [5:0] CODER_SETUP_OFS         = 6'h14;
  localparam logic [5:0] BIT_PULSE_WIDTH_OFS     = 6'h15;
  localparam logic [5:0] START_PULSE_WIDTH_OFS   = 6'h16;
  localparam logic [5:0] TYPE_B_FRAME_OFS        = 6'h17;
  localparam logic [5:0] FALLING_TIMES_OFS       = 6'h10;
  localparam logic [5:0] RISING_TIMES_OFS        = 6'h11;
  localparam logic [5:0] FALL_BOOST_OFS          = 6'h12;
  localparam logic [5:0] RISE_BOOST_OFS          = 6'h13;
  localparam logic [5:0] TX_STATUS_OFS           = 6'h14;

  // Field positions
  localparam int DRV1_INVERT_BIT = 7;
  localparam int ORIGIN_MSB      = 5;
  localparam int ORIGIN_LSB      = 4;
  localparam int DRV2_INVERT_BIT = 3;
  localparam int DRV2_CW_BIT     = 2;
  localparam int DRV2_RF_ON_BIT  = 1;
  localparam int DRV1_RF_ON_BIT  = 0;
  localparam int LEVEL_MSB       = 5;
  localparam int RATE_MSB        = 6;
  localparam int RATE_LSB        = 4;
  localparam int CODE_MSB        = 2;
  localparam int CODE_LSB        = 0;
  localparam int FIRST_TIME_MSB  = 7;
  localparam int FIRST_TIME_LSB  = 4;
  localparam int SECOND_TIME_MSB = 3;
  localparam int SECOND_TIME_LSB = 0;

  // Drive signal origin codes
  localparam logic [1:0] ORIGIN_CODER      = 2'h0;
  localparam logic [1:0] ORIGIN_CODER_FULL = 2'h1;
  localparam logic [1:0] ORIGIN_TEST_PIN   = 2'h2;
  localparam logic [1:0] ORIGIN_TRISTATE   = 2'h3;

  // Line coding that selects Type B framing
  localparam logic [2:0] CODING_TYPE_B = 3'h0;

  // Reset values
  localparam logic [7:0] TRANSMITTER_CONTROL_RST = 8'h18;
  localparam logic [7:0] CARRIER_LEVEL_RST       = 8'h3f;
  localparam logic [7:0] GENERIC_RST             = 8'h00;

  // Pulse width resolution in master clock cycles
  localparam int PULSE_STEP_CYCLES = 2;

  typedef enum logic [2:0] {
    PH_IDLE, PH_FALL1, PH_FALL2, PH_LOW, PH_RISE1, PH_RISE2
  } ovs_phase_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       sector;
    logic [5:0] addr;
    logic [7:0] data;
  } reg_access_t;

  typedef struct packed {
    logic       drive;
    logic [5:0] level;
    logic       oe_n;
  } driver_t;

  typedef struct packed {
    logic [2:0] bit_rate_code;
    logic [2:0] line_code_select;
    logic [8:0] bit_pulse_cycles;
    logic [8:0] start_pulse_cycles;
    logic [7:0] type_b_frame;
    logic       type_b_active;
  } coder_cfg_t;

endpackage : rf_tx_pkg

/* hdl/overshoot_phase_timer.sv */
`timescale 1ns/1ps
module overshoot_phase_timer (
  input  wire logic       mclk_in,
  input  wire logic       rst_in,
  input  wire logic       envelope_in,
  input  wire logic       full_depth_in,
  input  wire logic [7:0] falling_times_in,
  input  wire logic [7:0] rising_times_in,
  input  wire logic [5:0] carrier_level_in,
  input  wire logic [5:0] keyed_level_in,
  input  wire logic [5:0] fall_boost_in,
  input  wire logic [5:0] rise_boost_in,
  output logic      [5:0] level_out,
  output rf_tx_pkg::ovs_phase_t phase_out
);
  rf_tx_pkg::ovs_phase_t state_reg, state_next;
  logic [3:0] count_reg, count_next;
  logic       env_prev_reg;
  logic [5:0] level_reg, level_next;

  // Edges and phase durations
  wire       fall_edge = env_prev_reg & ~envelope_in;
  wire       rise_edge = ~env_prev_reg & envelope_in;
  wire [3:0] t1_fall   = falling_times_in[rf_tx_pkg::FIRST_TIME_MSB:rf_tx_pkg::FIRST_TIME_LSB];
  wire [3:0] t2_fall   = falling_times_in[rf_tx_pkg::SECOND_TIME_MSB:rf_tx_pkg::SECOND_TIME_LSB];
  wire [3:0] t1_rise   = rising_times_in[rf_tx_pkg::FIRST_TIME_MSB:rf_tx_pkg::FIRST_TIME_LSB];
  wire [3:0] t2_rise   = rising_times_in[rf_tx_pkg::SECOND_TIME_MSB:rf_tx_pkg::SECOND_TIME_LSB];
  wire       last      = (count_reg == 4'h1);
  wire [5:0] low_level = full_depth_in ? 6'h00 : keyed_level_in;

  // Phase sequencing, zero durations skip their phase
  always_comb begin
    state_next = state_reg;
    count_next = count_reg - 4'h1;
    if (fall_edge) begin
      state_next = (t1_fall != 4'h0) ? rf_tx_pkg::PH_FALL1 :
                   (t2_fall != 4'h0) ? rf_tx_pkg::PH_FALL2 : rf_tx_pkg::PH_LOW;
      count_next = (t1_fall != 4'h0) ? t1_fall : t2_fall;
    end else if (rise_edge) begin
      state_next = (t1_rise != 4'h0) ? rf_tx_pkg::PH_RISE1 :
                   (t2_rise != 4'h0) ? rf_tx_pkg::PH_RISE2 : rf_tx_pkg::PH_IDLE;
      count_next = (t1_rise != 4'h0) ? t1_rise : t2_rise;
    end else begin
      case (state_reg)
        rf_tx_pkg::PH_FALL1: if (last) begin
          state_next = (t2_fall != 4'h0) ? rf_tx_pkg::PH_FALL2 : rf_tx_pkg::PH_LOW;
          count_next = t2_fall;
        end
        rf_tx_pkg::PH_FALL2: if (last) state_next = rf_tx_pkg::PH_LOW;
        rf_tx_pkg::PH_RISE1: if (last) begin
          state_next = (t2_rise != 4'h0) ? rf_tx_pkg::PH_RISE2 : rf_tx_pkg::PH_IDLE;
          count_next = t2_rise;
        end
        rf_tx_pkg::PH_RISE2: if (last) state_next = rf_tx_pkg::PH_IDLE;
        rf_tx_pkg::PH_IDLE, rf_tx_pkg::PH_LOW: count_next = count_reg;
        default: state_next = rf_tx_pkg::PH_IDLE;
      endcase
    end
  end

  // Conductance per phase
  always_comb begin
    case (state_next)
      rf_tx_pkg::PH_FALL1: level_next = low_level;
      rf_tx_pkg::PH_FALL2: level_next = fall_boost_in;
      rf_tx_pkg::PH_LOW:   level_next = low_level;
      rf_tx_pkg::PH_RISE1: level_next = carrier_level_in;
      rf_tx_pkg::PH_RISE2: level_next = full_depth_in ? 6'h00 : rise_boost_in;
      default:             level_next = carrier_level_in;
    endcase
  end

  // State registers
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      state_reg    <= rf_tx_pkg::PH_IDLE;
      count_reg    <= 4'h0;
      env_prev_reg <= 1'h1;
      level_reg    <= 6'h00;
    end else begin
      state_reg    <= state_next;
      count_reg    <= count_next;
      env_prev_reg <= envelope_in;
      level_reg    <= level_next;
    end
  end

  assign level_out = level_reg;
  assign phase_out = state_reg;

  sequence fall_seen;
    env_prev_reg && !envelope_in && (t1_fall == 4'h2);
  endsequence

  AST_FALL_PHASE_TWO_CYCLES: assert property (@(posedge mclk_in) disable iff (rst_in)
    fall_seen ##1 (!envelope_in && !rise_edge)[*2] |=>
      (state_reg != rf_tx_pkg::PH_FALL1))
    else $error("first fall phase did not last its programmed time");

  AST_RISE_ENTERS_PHASE_FOUR: assert property (@(posedge mclk_in) disable iff (rst_in)
    rise_edge && (t1_rise != 4'h0) |=>
      (state_reg == rf_tx_pkg::PH_RISE1) && (level_reg == $past(carrier_level_in)))
    else $error("rise edge did not start phase four at carrier level");

  AST_LOW_HOLD_LEVEL: assert property (@(posedge mclk_in) disable iff (rst_in)
    (state_reg == rf_tx_pkg::PH_LOW) && $stable(envelope_in) && $past(state_reg) ==
      rf_tx_pkg::PH_LOW |-> (level_reg == ($past(full_depth_in) ? 6'h00 : $past(keyed_level_in))))
    else $error("held low phase level wrong");

  AST_BOOST_LEVEL: assert property (@(posedge mclk_in) disable iff (rst_in)
    (state_reg == rf_tx_pkg::PH_FALL2) |-> (level_reg == $past(fall_boost_in)))
    else $error("fall boost level not applied");

endmodule : overshoot_phase_timer

/* hdl/rf_transmit_driver_control.sv */
`timescale 1ns/1ps
module rf_transmit_driver_control (
  input  wire logic                   mclk_in,
  input  wire logic                   rst_in,
  input  wire rf_tx_pkg::reg_access_t reg_access_in,
  output logic                  [7:0] read_data_out,
  input  wire logic                   coder_envelope_in,
  input  wire logic                   coder_active_in,
  input  wire logic                   test_data_pin_in,
  input  wire logic                   carrier_in,
  input  wire logic                   field_drive_gate_in,
  input  wire logic                   external_field_sensing_in,
  output rf_tx_pkg::coder_cfg_t       coder_cfg_out,
  output rf_tx_pkg::driver_t          antenna_driver_one_out,
  output rf_tx_pkg::driver_t          antenna_driver_two_out
);

  logic [7:0] transmitter_control_reg;
  logic [7:0] carrier_drive_level_reg;
  logic [7:0] keyed_drive_level_reg;
  logic [7:0] coder_setup_reg;
  logic [7:0] bit_pulse_width_reg;
  logic [7:0] start_pulse_width_reg;
  logic [7:0] type_b_frame_setup_reg;
  logic [7:0] falling_phase_times_reg;
  logic [7:0] rising_phase_times_reg;
  logic [7:0] fall_boost_level_reg;
  logic [7:0] rise_boost_level_reg;
  logic [7:0] read_data_reg;
  logic [7:0] read_data_next;
  logic [1:0] test_pin_sync_reg;
  logic [1:0] carrier_sync_reg;
  logic [1:0] drive_reg;
  logic [5:0] level_reg [2];
  logic       oe_n_reg;
  logic [5:0] ovs_level;
  rf_tx_pkg::ovs_phase_t ovs_phase;

  // Write strobes per register
  wire s0 = reg_access_in.wr && (reg_access_in.sector == rf_tx_pkg::SECTOR_ZERO);
  wire s1 = reg_access_in.wr && (reg_access_in.sector == rf_tx_pkg::SECTOR_ONE);
  wire wr_control  = s0 && (reg_access_in.addr == rf_tx_pkg::TRANSMITTER_CONTROL_OFS);
  wire wr_carrier  = s0 && (reg_access_in.addr == rf_tx_pkg::CARRIER_LEVEL_OFS);
  wire wr_keyed    = s0 && (reg_access_in.addr == rf_tx_pkg::KEYED_LEVEL_OFS);
  wire wr_coder    = s0 && (reg_access_in.addr == rf_tx_pkg::CODER_SETUP_OFS);
  wire wr_bitw     = s0 && (reg_access_in.addr == rf_tx_pkg::BIT_PULSE_WIDTH_OFS);
  wire wr_sofw     = s0 && (reg_access_in.addr == rf_tx_pkg::START_PULSE_WIDTH_OFS);
  wire wr_typeb    = s0 && (reg_access_in.addr == rf_tx_pkg::TYPE_B_FRAME_OFS);
  wire wr_falltime = s1 && (reg_access_in.addr == rf_tx_pkg::FALLING_TIMES_OFS);
  wire wr_risetime = s1 && (reg_access_in.addr == rf_tx_pkg::RISING_TIMES_OFS);
  wire wr_fallb    = s1 && (reg_access_in.addr == rf_tx_pkg::FALL_BOOST_OFS);
  wire wr_riseb    = s1 && (reg_access_in.addr == rf_tx_pkg::RISE_BOOST_OFS);

  // Register file
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      transmitter_control_reg <= rf_tx_pkg::TRANSMITTER_CONTROL_RST;
      carrier_drive_level_reg <= rf_tx_pkg::CARRIER_LEVEL_RST;
      keyed_drive_level_reg   <= rf_tx_pkg::GENERIC_RST;
      coder_setup_reg         <= rf_tx_pkg::GENERIC_RST;
      bit_pulse_width_reg     <= rf_tx_pkg::GENERIC_RST;
      start_pulse_width_reg   <= rf_tx_pkg::GENERIC_RST;
      type_b_frame_setup_reg  <= rf_tx_pkg::GENERIC_RST;
      falling_phase_times_reg <= rf_tx_pkg::GENERIC_RST;
      rising_phase_times_reg  <= rf_tx_pkg::GENERIC_RST;
      fall_boost_level_reg    <= rf_tx_pkg::GENERIC_RST;
      rise_boost_level_reg    <= rf_tx_pkg::GENERIC_RST;
    end else begin
      if (wr_control)  transmitter_control_reg <= reg_access_in.data;
      if (wr_carrier)  carrier_drive_level_reg <= reg_access_in.data;
      if (wr_keyed)    keyed_drive_level_reg   <= reg_access_in.data;
      if (wr_coder)    coder_setup_reg         <= reg_access_in.data;
      if (wr_bitw)     bit_pulse_width_reg     <= reg_access_in.data;
      if (wr_sofw)     start_pulse_width_reg   <= reg_access_in.data;
      if (wr_typeb)    type_b_frame_setup_reg  <= reg_access_in.data;
      if (wr_falltime) falling_phase_times_reg <= reg_access_in.data;
      if (wr_risetime) rising_phase_times_reg  <= reg_access_in.data;
      if (wr_fallb)    fall_boost_level_reg    <= reg_access_in.data;
      if (wr_riseb)    rise_boost_level_reg    <= reg_access_in.data;
    end
  end

  // Control fields
  wire [1:0] origin     = transmitter_control_reg[rf_tx_pkg::ORIGIN_MSB:rf_tx_pkg::ORIGIN_LSB];
  wire [1:0] rf_on      = {transmitter_control_reg[rf_tx_pkg::DRV2_RF_ON_BIT],
                           transmitter_control_reg[rf_tx_pkg::DRV1_RF_ON_BIT]};
  wire [1:0] invert     = {transmitter_control_reg[rf_tx_pkg::DRV2_INVERT_BIT],
                           transmitter_control_reg[rf_tx_pkg::DRV1_INVERT_BIT]};
  wire [1:0] continuous = {transmitter_control_reg[rf_tx_pkg::DRV2_CW_BIT], 1'h0};
  wire       full_depth = (origin == rf_tx_pkg::ORIGIN_CODER_FULL);
  wire [5:0] cw_level   = carrier_drive_level_reg[rf_tx_pkg::LEVEL_MSB:0];
  wire [5:0] mod_level  = keyed_drive_level_reg[rf_tx_pkg::LEVEL_MSB:0];

  // Test pin and carrier inputs pass two flip-flops before use
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      test_pin_sync_reg <= 2'h3;
      carrier_sync_reg  <= 2'h0;
    end else begin
      test_pin_sync_reg <= {test_pin_sync_reg[0], test_data_pin_in};
      carrier_sync_reg  <= {carrier_sync_reg[0], carrier_in};
    end
  end

  // Envelope source: coder at rest reads high, or external test pin
  wire coder_env = coder_active_in ? coder_envelope_in : 1'h1;
  wire envelope  = (origin == rf_tx_pkg::ORIGIN_TEST_PIN) ? test_pin_sync_reg[1]
                                                         : coder_env;
  wire rf        = carrier_sync_reg[1];
  wire keyed     = ~envelope;

  // Driver release: tristate origin or gate low while sensing an outside field
  wire oe_n_next = (origin == rf_tx_pkg::ORIGIN_TRISTATE) ||
                   (external_field_sensing_in && !field_drive_gate_in);

  overshoot_phase_timer overshoot_phase_timer_i (
    .mclk_in          (mclk_in),
    .rst_in           (rst_in),
    .envelope_in      (envelope),
    .full_depth_in    (full_depth),
    .falling_times_in (falling_phase_times_reg),
    .rising_times_in  (rising_phase_times_reg),
    .carrier_level_in (cw_level),
    .keyed_level_in   (mod_level),
    .fall_boost_in    (fall_boost_level_reg[rf_tx_pkg::LEVEL_MSB:0]),
    .rise_boost_in    (rise_boost_level_reg[rf_tx_pkg::LEVEL_MSB:0]),
    .level_out        (ovs_level),
    .phase_out        (ovs_phase)
  );

  // Per-driver logic level and conductance
  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_drv
      wire       drive_next;
      wire [5:0] level_next;
      // Continuous carrier, baseband envelope, full-depth keyed, then modulated carrier
      assign drive_next = continuous[i] ? (rf_on[i] ? (rf ^ invert[i]) : invert[i]) :
                          !rf_on[i] ? (invert[i] | envelope) :
                          (full_depth && keyed) ? invert[i] :
                          (rf ^ invert[i]);
      assign level_next = continuous[i] ? ((rf_on[i] | invert[i]) ? cw_level : 6'h00) :
                          !rf_on[i] ? (envelope ? cw_level : (invert[i] ? mod_level : 6'h00)) :
                          (full_depth && keyed && invert[i]) ? cw_level :
                          ovs_level;
      always_ff @(posedge mclk_in) begin
        if (rst_in) begin
          drive_reg[i] <= 1'h0;
          level_reg[i] <= 6'h00;
        end else begin
          drive_reg[i] <= drive_next;
          level_reg[i] <= level_next;
        end
      end
    end
  endgenerate

  // Shared output enable
  always_ff @(posedge mclk_in) begin
    if (rst_in) oe_n_reg <= 1'h1;
    else        oe_n_reg <= oe_n_next;
  end

  assign antenna_driver_one_out = '{drive: drive_reg[0], level: level_reg[0], oe_n: oe_n_reg};
  assign antenna_driver_two_out = '{drive: drive_reg[1], level: level_reg[1], oe_n: oe_n_reg};

  // Coder configuration: pulse widths in two-clock steps, Type B framing
  assign coder_cfg_out.bit_rate_code      = coder_setup_reg[rf_tx_pkg::RATE_MSB:rf_tx_pkg::RATE_LSB];
  assign coder_cfg_out.line_code_select   = coder_setup_reg[rf_tx_pkg::CODE_MSB:rf_tx_pkg::CODE_LSB];
  assign coder_cfg_out.bit_pulse_cycles   =
    9'(bit_pulse_width_reg * rf_tx_pkg::PULSE_STEP_CYCLES);
  assign coder_cfg_out.start_pulse_cycles =
    9'(start_pulse_width_reg * rf_tx_pkg::PULSE_STEP_CYCLES);
  assign coder_cfg_out.type_b_frame       = type_b_frame_setup_reg;
  assign coder_cfg_out.type_b_active      =
    (coder_setup_reg[rf_tx_pkg::CODE_MSB:rf_tx_pkg::CODE_LSB] == rf_tx_pkg::CODING_TYPE_B);

  // Read mux, unmapped addresses read zero
  wire rd0 = reg_access_in.sector == rf_tx_pkg::SECTOR_ZERO;
  always_comb begin
    read_data_next = 8'h00;
    case ({rd0, reg_access_in.addr})
      {1'h1, rf_tx_pkg::TRANSMITTER_CONTROL_OFS}: read_data_next = transmitter_control_reg;
      {1'h1, rf_tx_pkg::CARRIER_LEVEL_OFS}:       read_data_next = carrier_drive_level_reg;
      {1'h1, rf_tx_pkg::KEYED_LEVEL_OFS}:         read_data_next = keyed_drive_level_reg;
      {1'h1, rf_tx_pkg::CODER_SETUP_OFS}:         read_data_next = coder_setup_reg;
      {1'h1, rf_tx_pkg::BIT_PULSE_WIDTH_OFS}:     read_data_next = bit_pulse_width_reg;
      {1'h1, rf_tx_pkg::START_PULSE_WIDTH_OFS}:   read_data_next = start_pulse_width_reg;
      {1'h1, rf_tx_pkg::TYPE_B_FRAME_OFS}:        read_data_next = type_b_frame_setup_reg;
      {1'h0, rf_tx_pkg::FALLING_TIMES_OFS}:       read_data_next = falling_phase_times_reg;
      {1'h0, rf_tx_pkg::RISING_TIMES_OFS}:        read_data_next = rising_phase_times_reg;
      {1'h0, rf_tx_pkg::FALL_BOOST_OFS}:          read_data_next = fall_boost_level_reg;
      {1'h0, rf_tx_pkg::RISE_BOOST_OFS}:          read_data_next = rise_boost_level_reg;
      {1'h0, rf_tx_pkg::TX_STATUS_OFS}:           read_data_next = {3'h0, oe_n_reg, envelope,
                                                                    3'(ovs_phase)};
      default:                                    read_data_next = 8'h00;
    endcase
  end

  // Read data register, updated on a read strobe
  always_ff @(posedge mclk_in) begin
    if (rst_in)                read_data_reg <= 8'h00;
    else if (reg_access_in.rd) read_data_reg <= read_data_next;
  end

  assign read_data_out = read_data_reg;

  // Checks on the driven outputs
  sequence gate_dropped;
    external_field_sensing_in && !field_drive_gate_in;
  endsequence

  sequence cw_set;
    continuous[1] && rf_on[1];
  endsequence

  AST_GATE_TRISTATES: assert property (@(posedge mclk_in) disable iff (rst_in)
    gate_dropped |=> antenna_driver_one_out.oe_n && antenna_driver_two_out.oe_n)
    else $error("drivers not released while field drive gate low");

  AST_CW_LEVEL: assert property (@(posedge mclk_in) disable iff (rst_in)
    cw_set ##1 $stable(cw_level) |->
      (antenna_driver_two_out.level == cw_level) &&
      (antenna_driver_two_out.drive == $past(rf ^ invert[1])))
    else $error("continuous carrier not at carrier level");

  AST_FULL_DEPTH_OFF: assert property (@(posedge mclk_in) disable iff (rst_in)
    full_depth && keyed && rf_on[0] && !invert[0] |=>
      (antenna_driver_one_out.drive == 1'h0))
    else $error("carrier driven during full depth keying interval");

  AST_IDLE_ENVELOPE_HIGH: assert property (@(posedge mclk_in) disable iff (rst_in)
    !coder_active_in && (origin != rf_tx_pkg::ORIGIN_TEST_PIN) |-> envelope)
    else $error("envelope low while coder idle");

  AST_KEYED_LEVEL: assert property (@(posedge mclk_in) disable iff (rst_in)
    (ovs_phase == rf_tx_pkg::PH_LOW) && !full_depth && rf_on[0] && !continuous[0] && keyed
      ##1 keyed |-> (antenna_driver_one_out.level == $past(mod_level)))
    else $error("keyed level not applied while envelope low");

  AST_CONTROL_READBACK: assert property (@(posedge mclk_in) disable iff (rst_in)
    wr_control ##1 (reg_access_in.rd && !reg_access_in.wr && rd0 &&
      reg_access_in.addr == rf_tx_pkg::TRANSMITTER_CONTROL_OFS) |=>
      (read_data_out == $past(reg_access_in.data, 2)))
    else $error("control register readback mismatch");

  AST_PULSE_STEP: assert property (@(posedge mclk_in) disable iff (rst_in)
    wr_bitw |=> (coder_cfg_out.bit_pulse_cycles == {$past(reg_access_in.data), 1'h0}))
    else $error("bit pulse width not in two-clock steps");

  AST_START_PULSE_STEP: assert property (@(posedge mclk_in) disable iff (rst_in)
    wr_sofw |=> (coder_cfg_out.start_pulse_cycles == {$past(reg_access_in.data), 1'h0}))
    else $error("start pulse width not in two-clock steps");

  // Origin and drive-mode checks
  sequence test_pin_origin;
    origin == rf_tx_pkg::ORIGIN_TEST_PIN;
  endsequence

  sequence differential_keying;
    (rf_on == 2'h3) && (invert == 2'h2) && !continuous[1] && !full_depth;
  endsequence

  AST_TRISTATE_ORIGIN: assert property (@(posedge mclk_in) disable iff (rst_in)
    (origin == rf_tx_pkg::ORIGIN_TRISTATE) |=>
      antenna_driver_one_out.oe_n && antenna_driver_two_out.oe_n)
    else $error("drivers not released for tristate origin");

  AST_TEST_PIN_ENVELOPE: assert property (@(posedge mclk_in) disable iff (rst_in)
    test_pin_origin |-> (envelope == test_pin_sync_reg[1]))
    else $error("test pin does not key the envelope");

  AST_DIFFERENTIAL: assert property (@(posedge mclk_in) disable iff (rst_in)
    differential_keying |=>
      (antenna_driver_one_out.drive != antenna_driver_two_out.drive))
    else $error("second driver not the inverse of the first");

  AST_BASEBAND_OUT: assert property (@(posedge mclk_in) disable iff (rst_in)
    !rf_on[0] && !invert[0] |=> (antenna_driver_one_out.drive == $past(envelope)))
    else $error("first driver does not carry the baseband envelope");

  AST_RATE_FIELD: assert property (@(posedge mclk_in) disable iff (rst_in)
    wr_coder |=> (coder_cfg_out.bit_rate_code ==
      $past(reg_access_in.data[rf_tx_pkg::RATE_MSB:rf_tx_pkg::RATE_LSB])))
    else $error("bit rate code not taken from coder setup");

endmodule : rf_transmit_driver_control

/* tb/antenna_network_model.sv */
`timescale 1ns/1ps
module antenna_network_model (
  input  wire rf_tx_pkg::driver_t driver_one_in,
  input  wire rf_tx_pkg::driver_t driver_two_in,
  output logic              [6:0] field_out
);
  // Tank field from both drivers; a released driver adds nothing
  assign field_out = (driver_one_in.oe_n ? 7'h00 : {1'b0, driver_one_in.level})
                   + (driver_two_in.oe_n ? 7'h00 : {1'b0, driver_two_in.level});
endmodule : antenna_network_model

/* tb/rf_transmit_driver_control_test.sv */
`timescale 1ns/1ps
module rf_transmit_driver_control_test;
  logic mclk_in = 1'b0, rst_in = 1'b1, env = 1'b1, gate = 1'b1, sense = 1'b0;
  logic act = 1'b1, tpin = 1'b0;
  rf_tx_pkg::reg_access_t ra = '0;
  rf_tx_pkg::coder_cfg_t  cfg;
  rf_tx_pkg::driver_t     d1, d2;
  logic [7:0] rd_q;
  logic [6:0] field;
  logic [7:0] codes [10] = '{8'h31, 8'h21, 8'h11, 8'h01, 8'h40, 8'h30, 8'h20, 8'h10, 8'h56, 8'h57};
  int n_fail = 0, comparisons = 0, cyc = 0, n;
  // Clock and run-length guard
  always #10 mclk_in = ~mclk_in;
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  rf_transmit_driver_control rf_transmit_driver_control_i (.mclk_in(mclk_in), .rst_in(rst_in),
    .reg_access_in(ra), .read_data_out(rd_q), .coder_envelope_in(env), .coder_active_in(act),
    .test_data_pin_in(tpin), .carrier_in(1'b1), .field_drive_gate_in(gate),
    .external_field_sensing_in(sense), .coder_cfg_out(cfg),
    .antenna_driver_one_out(d1), .antenna_driver_two_out(d2));
  antenna_network_model antenna_network_model_i (.driver_one_in(d1), .driver_two_in(d2),
    .field_out(field));
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr(input logic s, input logic [5:0] a, input logic [7:0] d);
    @(posedge mclk_in) ra <= {1'b1, 1'b0, s, a, d};
    @(posedge mclk_in) ra <= '0;
    #1;
  endtask : wr
  task automatic rd(input logic s, input logic [5:0] a, input logic [7:0] e);
    @(posedge mclk_in) ra <= {1'b0, 1'b1, s, a, 8'h00};
    @(posedge mclk_in) ra <= '0;
    #1 cmp(rd_q, e);
  endtask : rd
  // Counts settled cycles with driver one at level v, waiting first if asked
  task automatic run(input logic [5:0] v, input bit wait_first);
    n = 0;
    while (wait_first && d1.level !== v && n < 8) begin
      n++;
      @(posedge mclk_in) #1;
    end
    n = 0;
    while (d1.level === v && n < 20) begin
      n++;
      @(posedge mclk_in) #1;
    end
  endtask : run
  task automatic step_env(input logic v);
    @(posedge mclk_in) env <= v;
    #1;
  endtask : step_env
  task automatic tally_and_finish;
    if (n_fail == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  // Register, coder, overshoot and drive-mode sequence
  initial begin
    repeat (5) @(posedge mclk_in);
    rst_in <= 1'b0;
    rd(1'b0, 6'h11, 8'h18);
    rd(1'b0, 6'h12, 8'h3f);
    rd(1'b1, 6'h3f, 8'h00);
    foreach (codes[i]) begin
      wr(1'b0, 6'h14, codes[i]);
      cmp(cfg.bit_rate_code, codes[i][6:4]);
      cmp(cfg.line_code_select, codes[i][2:0]);
      cmp(cfg.type_b_active, codes[i][2:0] == 3'h0);
    end
    wr(1'b0, 6'h15, 8'h0d);
    wr(1'b0, 6'h16, 8'h20);
    wr(1'b0, 6'h17, 8'h5a);
    cmp({cfg.bit_pulse_cycles, cfg.start_pulse_cycles}, {9'h01a, 9'h040});
    cmp(cfg.type_b_frame, 8'h5a);
    wr(1'b0, 6'h13, 8'h10);
    wr(1'b1, 6'h10, 8'h23);
    wr(1'b1, 6'h11, 8'h24);
    wr(1'b1, 6'h12, 8'h05);
    wr(1'b1, 6'h13, 8'h0a);
    wr(1'b0, 6'h11, 8'h4b);
    repeat (3) @(posedge mclk_in);
    #1 cmp({d1.drive, d1.level, d1.oe_n, d2.drive, d2.level, d2.oe_n},
           {1'b1, 6'h3f, 2'h0, 6'h3f, 1'b0});
    rd(1'b1, 6'h14, 8'h08);
    step_env(1'b0);
    run(6'h10, 1'b1);
    cmp(n, 2);
    run(6'h05, 1'b0);
    cmp(n, 3);
    cmp(d1.level, 6'h10);
    step_env(1'b1);
    run(6'h3f, 1'b1);
    cmp(n, 2);
    run(6'h0a, 1'b0);
    cmp(n, 4);
    cmp(d1.level, 6'h3f);
    @(posedge mclk_in) {act, env} <= 2'h0;
    repeat (6) @(posedge mclk_in);
    #1 cmp(d1.level, 6'h3f);
    @(posedge mclk_in) {act, env} <= 2'h3;
    wr(1'b0, 6'h11, 8'h6b);
    repeat (12) @(posedge mclk_in);
    #1 cmp({d1.level, d2.level}, {6'h10, 6'h10});
    @(posedge mclk_in) tpin <= 1'b1;
    repeat (14) @(posedge mclk_in);
    #1 cmp({d1.drive, d1.level}, 7'h7f);
    wr(1'b0, 6'h11, 8'h5b);
    step_env(1'b0);
    repeat (12) @(posedge mclk_in);
    #1 cmp({d1.drive, d1.level}, 7'h00);
    wr(1'b0, 6'h11, 8'h46);
    repeat (3) @(posedge mclk_in);
    #1 cmp({d1.drive, d2.drive, d2.level}, {2'h1, 6'h3f});
    step_env(1'b1);
    wr(1'b0, 6'h11, 8'h7b);
    repeat (3) @(posedge mclk_in);
    #1 cmp({d1.oe_n, field}, 8'h80);
    wr(1'b0, 6'h11, 8'h4b);
    @(posedge mclk_in) {sense, gate} <= 2'h2;
    repeat (3) @(posedge mclk_in);
    #1 cmp({d1.oe_n, d2.oe_n, field}, 9'h180);
    tally_and_finish();
  end
endmodule : rf_transmit_driver_control_test
